//--- design/qwrc_pkg.sv
// shared constants, opcodes, carriers and states of the quad wiper control
`default_nettype none
package qwrc_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int POT_N = 4;
  localparam int SLOT_N = 4;
  localparam int SAVED_N = POT_N * SLOT_N;
  localparam int WIPER_W = 6;
  localparam int TAP_N = 64;
  localparam int BYTE_W = 8;

  // ****************************************************************
  // slave address, counts and reset values
  // ****************************************************************
  localparam logic [2:0] ADDR_HI = 3'h2;  // fixed upper address bits
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;
  localparam logic [WIPER_W-1:0] WIPER_STEP = 6'h01;
  localparam logic [WIPER_W-1:0] WIPER_RST = 6'h00;
  localparam logic [WIPER_W-1:0] SAVED_RST = 6'h20;
  localparam logic [1:0] READ_PAD = 2'h0;

  // ****************************************************************
  // instruction opcodes (upper nibble of the instruction byte)
  // ****************************************************************
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_INCDEC = 4'h2;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SAVED = 4'hB;
  localparam logic [3:0] OP_WR_SAVED = 4'hC;
  localparam logic [3:0] OP_RECALL = 4'hD;
  localparam logic [3:0] OP_STORE = 4'hE;

  // instruction byte layout
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] slot;
    logic [1:0] pot;
  } qwrc_instr_s;

  // pins that enter the core clock domain through synchronisers
  typedef struct packed {
    logic [3:0] strap;
    logic wp;
    logic sda;
    logic scl;
  } qwrc_pins_s;

  localparam qwrc_instr_s INSTR_RST = '{op: OP_NONE, slot: 2'h0, pot: 2'h0};
  localparam qwrc_pins_s PINS_RST = '{strap: 4'h0, wp: 1'b1, sda: 1'b1,
                                      scl: 1'b1};

  typedef enum {
    ST_INIT,
    ST_IDLE,
    ST_IGNORE,
    ST_ADDR,
    ST_INSTR,
    ST_DATA,
    ST_ACK,
    ST_ACK_END,
    ST_TX,
    ST_MACK
  } qwrc_state_e;

endpackage
`default_nettype wire

//--- design/qwrc_top.sv
// serial-bus slave and wiper/saved-setting store of the quad potentiometer
`default_nettype none

// Overview of operation
// - reset recall copies first saved setting to wiper
// - four independent 6-bit wiper position registers
// - four 6-bit saved settings per wiper
// - protect low blocks saved writes, not wipers
// - answer only when address matches strap inputs
// - exactly one tap selected per wiper value
// - master reads and writes both register kinds
// - recall and store between wiper and slot
// - increment/decrement mode steps the wiper
// - data line driven only open-drain low
// - serial clock from master times all transfers
module qwrc_top
  import qwrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic nv_protect_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit3,
  output logic [POT_N-1:0][TAP_N-1:0] tap_sel
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // index of a saved slot in the flat store
  function automatic logic [3:0] saved_idx(input qwrc_instr_s ins);
    saved_idx = {ins.pot, ins.slot};
  endfunction

  // one-hot tap select from a wiper position
  function automatic logic [TAP_N-1:0] tap_decode(
    input logic [WIPER_W-1:0] pos
  );
    tap_decode = {{(TAP_N-1){1'b0}}, 1'b1} << pos;
  endfunction

  // ****************************************************************
  // serial clock domain: receive shifter
  // ****************************************************************
  logic [BYTE_W-1:0] rx_shift_q;
  logic [BYTE_W-1:0] rx_shift_d;

  // shift the data line in on every rising serial clock
  always_comb begin
    rx_shift_d = {rx_shift_q[BYTE_W-2:0], sda_i};
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      rx_shift_q <= '0;
    end else begin
      rx_shift_q <= rx_shift_d;
    end
  end

  // ****************************************************************
  // pin synchronisers into the core domain
  // ****************************************************************
  qwrc_pins_s pins_raw;
  qwrc_pins_s meta_q;
  qwrc_pins_s sync_q;
  qwrc_pins_s prev_q;

  assign pins_raw = '{strap: {addr_strap_bit3, addr_strap_bit2,
                              addr_strap_bit1, addr_strap_bit0},
                      wp: nv_protect_n, sda: sda_i, scl: scl};

  // two flops per pin, a third copy for edge detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= PINS_RST;
      sync_q <= PINS_RST;
      prev_q <= PINS_RST;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // bus events seen through the synchronisers
  assign scl_rise = sync_q.scl & ~prev_q.scl;
  assign scl_fall = ~sync_q.scl & prev_q.scl;
  assign bus_start = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
  assign bus_stop = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;

  // ****************************************************************
  // protocol engine and register store
  // ****************************************************************
  qwrc_state_e state_q, state_d;
  qwrc_state_e ret_q, ret_d;
  logic [2:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic [BYTE_W-1:0] tx_q, tx_d;
  qwrc_instr_s instr_q, instr_d;
  logic [WIPER_W-1:0] wiper_q [POT_N];
  logic [WIPER_W-1:0] wiper_d [POT_N];
  logic [WIPER_W-1:0] saved_q [SAVED_N];
  logic [WIPER_W-1:0] saved_d [SAVED_N];

  logic byte_done;
  logic [BYTE_W-1:0] rx_byte;
  qwrc_instr_s rx_instr;
  logic [BYTE_W-1:0] read_val;
  logic addr_match;

  // the shifter is stable for the rest of the bit when the core sees it
  assign byte_done = scl_rise && (cnt_q == BIT_LAST);
  assign rx_byte = rx_shift_q;
  assign rx_instr = qwrc_instr_s'(rx_byte);
  assign addr_match = (rx_byte[7:5] == ADDR_HI) &&
                      (rx_byte[4:1] == sync_q.strap);
  // value returned on a read transfer
  assign read_val = (instr_q.op == OP_RD_SAVED) ?
                    {READ_PAD, saved_q[saved_idx(instr_q)]} :
                    {READ_PAD, wiper_q[instr_q.pot]};

  // next-state and register updates
  always_comb begin
    state_d = state_q;
    ret_d = ret_q;
    cnt_d = cnt_q;
    ack_d = ack_q;
    oe_d = oe_q;
    tx_d = tx_q;
    instr_d = instr_q;
    wiper_d = wiper_q;
    saved_d = saved_q;
    unique case (state_q)
      ST_INIT: begin
        // recall first slot of every wiper after reset
        for (int p = 0; p < POT_N; p++) begin
          wiper_d[p] = saved_q[p*SLOT_N];
        end
        state_d = ST_IDLE;
      end
      ST_IDLE, ST_IGNORE: begin
        state_d = state_q;
      end
      ST_ADDR: begin
        if (scl_rise) begin
          cnt_d = cnt_q + BIT_ONE;
        end
        if (byte_done) begin
          ack_d = addr_match;
          ret_d = rx_byte[0] ? ST_TX : ST_INSTR;
          state_d = addr_match ? ST_ACK : ST_IGNORE;
        end
      end
      ST_INSTR: begin
        if (scl_rise) begin
          cnt_d = cnt_q + BIT_ONE;
        end
        if (byte_done) begin
          instr_d = rx_instr;
          ret_d = ST_DATA;
          state_d = ST_ACK;
          // decode of the instruction byte
          unique case (rx_instr.op)
            OP_RD_WIPER, OP_WR_WIPER, OP_RD_SAVED, OP_WR_SAVED,
            OP_INCDEC: begin
              ack_d = 1'b1;
            end
            OP_RECALL: begin
              wiper_d[rx_instr.pot] = saved_q[saved_idx(rx_instr)];
              ack_d = 1'b1;
            end
            OP_STORE: begin
              if (sync_q.wp) begin
                saved_d[saved_idx(rx_instr)] = wiper_q[rx_instr.pot];
              end
              ack_d = sync_q.wp;
            end
            default: begin
              ack_d = 1'b0;
            end
          endcase
        end
      end
      ST_DATA: begin
        if (scl_rise) begin
          cnt_d = cnt_q + BIT_ONE;
        end
        if (byte_done) begin
          state_d = ST_ACK;
          ret_d = ST_DATA;
          ack_d = 1'b0;
          unique case (instr_q.op)
            OP_WR_WIPER: begin
              wiper_d[instr_q.pot] = rx_byte[WIPER_W-1:0];
              ack_d = 1'b1;
            end
            OP_WR_SAVED: begin
              if (sync_q.wp) begin
                saved_d[saved_idx(instr_q)] = rx_byte[WIPER_W-1:0];
              end
              ack_d = sync_q.wp;
            end
            OP_INCDEC: begin
              // bit 0 high steps up, low steps down, held at the ends
              if (rx_byte[0]) begin
                if (wiper_q[instr_q.pot] != WIPER_MAX) begin
                  wiper_d[instr_q.pot] = wiper_q[instr_q.pot] + WIPER_STEP;
                end
              end else if (wiper_q[instr_q.pot] != WIPER_MIN) begin
                wiper_d[instr_q.pot] = wiper_q[instr_q.pot] - WIPER_STEP;
              end
              ack_d = 1'b1;
            end
            default: begin
              ack_d = 1'b0;
            end
          endcase
        end
      end
      ST_ACK: begin
        // pull the line low for the acknowledge bit
        if (scl_fall) begin
          oe_d = ack_q;
          state_d = ST_ACK_END;
        end
      end
      ST_ACK_END: begin
        if (scl_fall) begin
          cnt_d = BIT_ZERO;
          oe_d = 1'b0;
          if (!ack_q) begin
            state_d = ST_IGNORE;
          end else if (ret_q == ST_TX) begin
            oe_d = ~read_val[BYTE_W-1];
            tx_d = read_val << 1;
            state_d = ST_TX;
          end else begin
            state_d = ret_q;
          end
        end
      end
      ST_TX: begin
        // next bit on each falling clock, release after the last
        if (scl_fall) begin
          if (cnt_q == BIT_LAST) begin
            oe_d = 1'b0;
            cnt_d = BIT_ZERO;
            state_d = ST_MACK;
          end else begin
            oe_d = ~tx_q[BYTE_W-1];
            tx_d = tx_q << 1;
            cnt_d = cnt_q + BIT_ONE;
          end
        end
      end
      ST_MACK: begin
        // master acknowledge asks for another byte
        if (scl_rise) begin
          ack_d = ~sync_q.sda;
          ret_d = ST_TX;
          state_d = sync_q.sda ? ST_IGNORE : ST_ACK_END;
        end
      end
    endcase
    // start and stop override any transfer in progress
    if (state_q != ST_INIT) begin
      if (bus_start) begin
        state_d = ST_ADDR;
        cnt_d = BIT_ZERO;
        oe_d = 1'b0;
      end else if (bus_stop) begin
        state_d = ST_IDLE;
        oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_INIT;
      ret_q <= ST_IDLE;
      cnt_q <= BIT_ZERO;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      tx_q <= '0;
      instr_q <= INSTR_RST;
      for (int p = 0; p < POT_N; p++) begin
        wiper_q[p] <= WIPER_RST;
      end
      for (int s = 0; s < SAVED_N; s++) begin
        saved_q[s] <= SAVED_RST;
      end
    end else begin
      state_q <= state_d;
      ret_q <= ret_d;
      cnt_q <= cnt_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      tx_q <= tx_d;
      instr_q <= instr_d;
      wiper_q <= wiper_d;
      saved_q <= saved_d;
    end
  end

  // ****************************************************************
  // tap selection outputs
  // ****************************************************************
  logic [POT_N-1:0][TAP_N-1:0] tap_q;

  // one registered one-hot tap word per potentiometer
  for (genvar p = 0; p < POT_N; p++) begin : g_tap
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        tap_q[p] <= '0;
      end else begin
        tap_q[p] <= tap_decode(wiper_q[p]);
      end
    end
  end

  // open-drain: only ever drive low
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign tap_sel = tap_q;

endmodule
`default_nettype wire

//--- sim/qwrc_top_asserts.sv
// port checker of the quad wiper control
`default_nettype none
module qwrc_top_asserts
  import qwrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic nv_protect_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit3,
  input wire logic [POT_N-1:0][TAP_N-1:0] tap_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // edge count since reset release
  // ****************************************
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  // saturating count
  always_comb begin
    cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
  end
  // register the count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // port properties
  // ****************************************
  property p_sda_low;
    !sda_o;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_rst_zero;
    cnt_q == 3'h0 |-> tap_sel == '0 && !sda_oe;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("outputs not idle after reset");
  property p_onehot;
    cnt_q > 3'h3 |-> $onehot(tap_sel[0]) && $onehot(tap_sel[1])
      && $onehot(tap_sel[2]) && $onehot(tap_sel[3]);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("tap select not one-hot");
  property p_recall;
    cnt_q == 3'h5 |-> tap_sel[0][32] && tap_sel[1][32]
      && tap_sel[2][32] && tap_sel[3][32];
  endproperty
  a_recall: assert property (p_recall)
    else $error("first saved setting not recalled");
  property p_oe_min;
    $rose(sda_oe) |-> sda_oe[*3];
  endproperty
  a_oe_min: assert property (p_oe_min)
    else $error("data drive shorter than a bit");
  property p_oe_max;
    $rose(sda_oe) |-> ##[1:45] !sda_oe;
  endproperty
  a_oe_max: assert property (p_oe_max)
    else $error("data drive held too long");
  property p_oe_idle;
    scl [*6] |=> $stable(sda_oe);
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data drive moved without clock");
  property p_tap_idle;
    cnt_q == 3'h7 ##0 scl [*8] |=> $stable(tap_sel);
  endproperty
  a_tap_idle: assert property (p_tap_idle)
    else $error("tap moved without clock");
endmodule
bind qwrc_top qwrc_top_asserts u_qwrc_top_asserts (
  .core_clk(core_clk), .rst(rst), .scl(scl), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .nv_protect_n(nv_protect_n),
  .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1),
  .addr_strap_bit2(addr_strap_bit2), .addr_strap_bit3(addr_strap_bit3),
  .tap_sel(tap_sel)
);
`default_nettype wire

//--- sim/qwrc_mst.sv
// serial-bus master model that drives clock and data
`default_nettype none
module qwrc_mst (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // bus idles released, clock high
  // ****************************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit slot; low phase is twice the high phase so the device
  // output has settled before the clock rises
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = !b;
    #40 scl = 1'b1;
    r = sda;
    #40 scl = 1'b0;
  endtask
  // data falls while clock high
  task automatic start;
    sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  // data rises while clock high, clock then stands still
  task automatic stop;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask
  // byte out, msb first, line released for the ack
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask
  // byte in, then own ack level
  task automatic rb(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(mack, r);
  endtask
endmodule
`default_nettype wire

//--- sim/qwrc_top_tb_top.sv
// self-checking bench of the quad wiper control
`default_nettype none
module qwrc_top_tb_top
  import qwrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, nv_protect_n, scl, m_low, sda_o, sda_oe, a;
  logic [3:0] strap;
  logic [POT_N-1:0][TAP_N-1:0] tap_sel;
  logic [5:0] wip [POT_N];
  logic [5:0] sav [SAVED_N];
  logic [1:0] p, s;
  logic [5:0] v;
  int bad_count, n_tests;
  int unsigned seed;
  wire logic sda_i;
  // pulled-up line, low while either side pulls
  assign sda_i = !(sda_oe | m_low);
  // ****************************************
  // clock, design and bus master
  // ****************************************
  always #12.5 core_clk = ~core_clk;
  qwrc_top u_qwrc_top (.core_clk(core_clk), .rst(rst), .scl(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .nv_protect_n(nv_protect_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .addr_strap_bit3(strap[3]), .tap_sel(tap_sel));
  qwrc_mst u_qwrc_mst (.scl(scl), .sda_low(m_low), .sda(sda_i));
  // compare and count
  task automatic chk(input string nm, input logic [63:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // write frame: address, instruction, optional data byte
  task automatic cmd(input logic [3:0] op, input logic [1:0] sl, po,
                     input logic [7:0] d, input logic dat, ea, ed);
    logic k;
    u_qwrc_mst.start();
    u_qwrc_mst.wb({ADDR_HI, strap, 1'b0}, k);
    chk("address ack", k, 1'b0);
    u_qwrc_mst.wb({op, sl, po}, k);
    chk("instruction ack", k, ea);
    if (dat) begin
      u_qwrc_mst.wb(d, k);
      chk("data ack", k, ed);
    end
    u_qwrc_mst.stop();
  endtask
  // select a register, then read it back
  task automatic rd(input logic [3:0] op, input logic [1:0] sl, po,
                    input logic [5:0] e);
    logic k;
    logic [7:0] d;
    cmd(op, sl, po, 8'h00, 1'b0, 1'b0, 1'b0);
    u_qwrc_mst.start();
    u_qwrc_mst.wb({ADDR_HI, strap, 1'b1}, k);
    chk("read address ack", k, 1'b0);
    // master ack asks for the same register once more
    u_qwrc_mst.rb(1'b0, d);
    chk("read data", d, {2'b00, e});
    u_qwrc_mst.rb(1'b1, d);
    u_qwrc_mst.stop();
    chk("repeat read data", d, {2'b00, e});
  endtask
  // expected wiper after one step, held at both ends
  function automatic logic [5:0] step_exp(input logic [5:0] w,
                                          input logic up);
    if (up) begin
      return (w == 6'h3F) ? w : w + 6'h01;
    end
    return (w == 6'h00) ? w : w - 6'h01;
  endfunction
  // tap select against the wiper model
  task automatic taps;
    for (int i = 0; i < POT_N; i++) begin
      chk("tap select", tap_sel[i], 64'h1 << wip[i]);
    end
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    nv_protect_n = 1'b1;
    seed = $urandom(57732);
    strap = 4'($urandom);
    for (int i = 0; i < SAVED_N; i++) sav[i] = SAVED_RST;
    for (int i = 0; i < POT_N; i++) wip[i] = sav[i * SLOT_N];
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (6) @(negedge core_clk);
    for (int i = 0; i < POT_N; i++) begin
      rd(OP_RD_WIPER, 2'h0, 2'(i), wip[i]);
    end
    taps();
    repeat (8) begin
      p = 2'($urandom);
      s = 2'($urandom);
      v = 6'($urandom);
      cmd(OP_WR_WIPER, 2'h0, p, {2'b00, v}, 1'b1, 1'b0, 1'b0);
      wip[p] = v;
      v = 6'($urandom);
      cmd(OP_WR_SAVED, s, p, {2'b00, v}, 1'b1, 1'b0, 1'b0);
      sav[{p, s}] = v;
      rd(OP_RD_SAVED, s, p, sav[{p, s}]);
      rd(OP_RD_WIPER, s, p, wip[p]);
      cmd(OP_STORE, s, p ^ 2'h1, 8'h00, 1'b0, 1'b0, 1'b0);
      sav[{p ^ 2'h1, s}] = wip[p ^ 2'h1];
      rd(OP_RD_SAVED, s, p ^ 2'h1, sav[{p ^ 2'h1, s}]);
      cmd(OP_RECALL, s, p, 8'h00, 1'b1, 1'b0, 1'b1);
      wip[p] = sav[{p, s}];
      taps();
    end
    // step past both ends
    for (int d = 0; d < 2; d++) begin
      cmd(OP_WR_WIPER, 2'h0, 2'h1, d ? 8'h3E : 8'h01, 1'b1, 1'b0, 1'b0);
      wip[1] = d ? 6'h3E : 6'h01;
      repeat (2) begin
        cmd(OP_INCDEC, 2'h0, 2'h1, 8'(d), 1'b1, 1'b0, 1'b0);
        wip[1] = step_exp(wip[1], d[0]);
        taps();
      end
      taps();
    end
    // protect low: saved writes refused, wiper writes taken
    @(negedge core_clk);
    nv_protect_n = 1'b0;
    repeat (4) @(negedge core_clk);
    cmd(OP_WR_SAVED, 2'h3, 2'h2, 8'h11, 1'b1, 1'b0, 1'b1);
    cmd(OP_STORE, 2'h3, 2'h2, 8'h00, 1'b0, 1'b1, 1'b0);
    cmd(OP_WR_WIPER, 2'h0, 2'h2, 8'h2A, 1'b1, 1'b0, 1'b0);
    wip[2] = 6'h2A;
    rd(OP_RD_SAVED, 2'h3, 2'h2, sav[{2'h2, 2'h3}]);
    taps();
    @(negedge core_clk);
    nv_protect_n = 1'b1;
    cmd(4'h5, 2'h0, 2'h0, 8'h00, 1'b0, 1'b1, 1'b0);
    // foreign address, then a new strap
    u_qwrc_mst.start();
    u_qwrc_mst.wb({ADDR_HI, ~strap, 1'b0}, a);
    u_qwrc_mst.stop();
    chk("foreign address ack", a, 1'b1);
    @(negedge core_clk);
    strap = ~strap;
    repeat (4) @(negedge core_clk);
    rd(OP_RD_WIPER, 2'h0, 2'h2, wip[2]);
    stop_test();
  end
endmodule
`default_nettype wire
